// >>> inc/phy_strap_regs.svh
// register indices, field positions, reset values and timing counts
`ifndef PHY_STRAP_REGS_SVH
`define PHY_STRAP_REGS_SVH

// register indices; byte address is four times the index
`define REG_CTRL_IDX      5'h00
`define REG_ID2_IDX       5'h03
`define REG_ADV_IDX       5'h04
`define REG_PHYCTL_IDX    5'h14
`define REG_RXERR_IDX     5'h15
`define REG_STRAP_IDX     5'h1b
`define REG_INT_IDX       5'h1f

// field positions
`define CTRL_DUPLEX_BIT   8
`define CTRL_ISO_BIT      10
`define ADV_ASYM_BIT      11
`define PHYCTL_PRE100_BIT 7
`define PHYCTL_PRE10_BIT  6
`define INT_POL_BIT       9
`define INT_EN_LSB        4

// reset values
`define CTRL_RST          16'h0000
`define ADV_RST           16'h01e1
`define PHYCTL_RST        16'h0000
`define ID2_MODEL_RST     12'h5a0

// strap settle: pin synchroniser depth before capture
`define STRAP_SETTLE      2'h2

// reference clock rates per interface mode, in Hz
`define REF_MII_HZ        25000000
`define REF_RMII_HZ       50000000
`define REF_SMII_HZ       125000000

`endif

// >>> inc/phy_strap_pkg.sv
// types shared by the pin strap and mux block
package phy_strap_pkg;

  typedef enum logic [2:0] {
    MODE_MII      = 3'b000,
    MODE_RMII     = 3'b001,
    MODE_SMII     = 3'b010,
    MODE_RSVD3    = 3'b011,
    MODE_MII_PRE  = 3'b100,
    MODE_RMII_B2B = 3'b101,
    MODE_MII_B2B  = 3'b110,
    MODE_RSVD7    = 3'b111
  } mode_t;

  typedef enum logic [1:0] {
    REF_25M  = 2'b00,
    REF_50M  = 2'b01,
    REF_125M = 2'b10
  } ref_sel_t;

  typedef struct packed {
    logic [4:0] phy_station_address;
    mode_t      interface_config;
    logic       duplex_full;
    logic       isolate;
  } strap_t;

  // receive side from the phy core toward the mac pins
  typedef struct packed {
    logic [3:0] rxd;
    logic       rx_dv;
    logic       rx_er;
    logic       sym_err;
    logic       crs;
    logic       col;
    logic       smii_rx;
    logic       tx_clk;
  } rx_core_t;

  // transmit side from the mac pins toward the phy core
  typedef struct packed {
    logic       tx_en;
    logic [3:0] txd;
    logic       tx_clk_in;
    logic       smii_sync;
    logic       mdio_bit;
    logic       mdio_stb;
  } tx_core_t;

endpackage

// >>> hw/pin_sync.sv
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,    // system clock
  input  wire logic         presetn, // async reset, active low
  input  wire logic [W-1:0] d_in,    // asynchronous inputs
  output logic      [W-1:0] q_out    // synchronised outputs
);
  logic [W-1:0] meta_r;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r[g] <= 1'b0;
          q_out[g]  <= 1'b0;
        end else begin
          meta_r[g] <= d_in[g];
          q_out[g]  <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule

// >>> hw/rx_err_counter.sv
// saturating receive error counter, cleared when read
`timescale 1ns/1ps
module rx_err_counter #(
  parameter int W = 16
) (
  input  wire logic         pclk,    // system clock
  input  wire logic         presetn, // async reset, active low
  input  wire logic         inc,     // one error event
  input  wire logic         clr,     // read strobe, clears
  output logic      [W-1:0] count    // current count
);
  logic [W-1:0] cnt_nxt;

  // an error in the clearing cycle is kept as a count of one
  always_comb begin
    cnt_nxt = count;
    if (clr) begin
      cnt_nxt = inc ? W'(1) : '0;
    end else if (inc && (count != {W{1'b1}})) begin
      cnt_nxt = count + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else begin
      count <= cnt_nxt;
    end
  end
endmodule

// >>> hw/phy_pin_strap_mux.sv
// mac-side strap capture, pin mux and register file of a 10/100 phy
// Functional notes
// - Latch receive data pins 3,2,1 as address bits 0,1,2 at reset.
// - Latch receive data bit 0 pin into control register duplex bit 8.
// - Latch receive-data-valid pin as interface configuration bit 2.
// - Latch receive-error pin as the isolate setting.
// - In RMII, data-valid pin carries combined carrier sense and data valid.
// - Interrupt polarity from register 1Fh bit 9, default active low.
// - Software picks interrupt sources and reads status in register 1Fh.
// - Transmit clock pin is output in MII, input in MII back-to-back.
// - Reference clock is 25, 50 or 125 MHz by mode; crystal only MII.
// - Management data is sampled on management clock rising edges.
// - Register 14h: bit 7 preamble restore 100, bit 6 preamble restore 10.
// - Configuration strap 100 means MII with 100 Mbps preamble restore.
// - Advertisement register 4h bit 11 is asymmetric pause.
// - Symbol errors count as receive errors on pin and in register 15h.
// - Duplex strap never changes advertisement bits 8 and 6.
// - Identifier register 3h bits 3:0 report silicon revision.
// - Strap pins are inputs during reset, outputs afterwards; isolate keeps all undriven, RMII drives rxd 1:0, dv and er, SMII only rxd 0.
// - Strap 000 MII, 001 RMII, 010 SMII, 101 RMII b2b, 110 MII b2b.
// - Address bits 4 and 3 forced to zero.
// - Duplex strap high selects half duplex, low selects full.
`timescale 1ns/1ps
`include "phy_strap_regs.svh"
module phy_pin_strap_mux #(
  parameter logic [3:0] SILICON_REV = 4'h1, // arbitrary revision value
  parameter int         INT_SRC     = 4     // interrupt sources
) (
  input  wire logic                  pclk,             // 125 MHz clock
  input  wire logic                  presetn,          // async reset, low
  input  wire logic                  psel,             // apb select
  input  wire logic                  penable,          // apb enable
  input  wire logic                  pwrite,           // apb direction
  input  wire logic [7:0]            paddr,            // apb byte address
  input  wire logic [31:0]           pwdata,           // apb write data
  output logic      [31:0]           prdata,           // apb read data
  output logic                       pready,           // apb ready
  output logic                       pslverr,          // apb error
  input  wire logic [3:0]            rxd_i,            // rxd pins in
  output logic      [3:0]            rxd_o,            // rxd pins out
  output logic      [3:0]            rxd_oe,           // rxd pins enable
  input  wire logic                  rxdv_i,           // dv pin in
  output logic                       rxdv_o,           // dv pin out
  output logic                       rxdv_oe,          // dv pin enable
  input  wire logic                  rxer_i,           // error pin in
  output logic                       rxer_o,           // error pin out
  output logic                       rxer_oe,          // error pin enable
  input  wire logic                  col_i,            // col pin in
  output logic                       col_o,            // col pin out
  output logic                       col_oe,           // col pin enable
  input  wire logic                  crs_i,            // crs pin in
  output logic                       crs_o,            // crs pin out
  output logic                       crs_oe,           // crs pin enable
  input  wire logic                  transmit_clock_pin_i,  // tx clock in
  output logic                       transmit_clock_pin_o,  // tx clock out
  output logic                       transmit_clock_pin_oe, // tx clock en
  input  wire logic                  txen_i,           // tx enable pin
  input  wire logic [3:0]            txd_i,            // tx data pins
  input  wire logic                  mdc_i,            // management clock
  input  wire logic                  mdio_i,           // management data in
  output logic                       mdio_o,           // management data out
  output logic                       mdio_oe,          // management data en
  output logic                       interrupt_output, // interrupt pin
  input  wire phy_strap_pkg::rx_core_t rx_core,        // core receive side
  input  wire logic                  mdio_drv,         // core drives mdio
  input  wire logic                  mdio_bit_out,     // core mdio bit
  input  wire logic [INT_SRC-1:0]    int_evt,          // core event pulses
  output phy_strap_pkg::tx_core_t    tx_core,          // to core, registered
  output phy_strap_pkg::strap_t      strap,            // latched straps
  output phy_strap_pkg::ref_sel_t    ref_sel,          // ref clock rate
  output logic                       crystal_input_allowed, // crystal ok
  output logic                       straps_valid      // capture done
);
  localparam int NSYNC = 16;

  // pin synchronisers
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_s;
  assign pin_raw = {mdio_i, mdc_i, txd_i, txen_i, transmit_clock_pin_i,
                    crs_i, col_i, rxer_i, rxdv_i, rxd_i};

  pin_sync #(.W(NSYNC)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    (pin_raw),
    .q_out   (pin_s)
  );

  logic [3:0] s_rxd;
  logic       s_rxdv, s_rxer, s_col, s_crs, s_txc, s_txen, s_mdc, s_mdio;
  logic [3:0] s_txd;
  assign s_rxd  = pin_s[3:0];
  assign s_rxdv = pin_s[4];
  assign s_rxer = pin_s[5];
  assign s_col  = pin_s[6];
  assign s_crs  = pin_s[7];
  assign s_txc  = pin_s[8];
  assign s_txen = pin_s[9];
  assign s_txd  = pin_s[13:10];
  assign s_mdc  = pin_s[14];
  assign s_mdio = pin_s[15];

  // strap capture: wait for the synchronisers to hold real pin levels
  logic [1:0]            settle_r, settle_nxt;
  logic                  done_r, done_nxt;
  phy_strap_pkg::strap_t strap_r, strap_nxt;
  logic                  capture;

  assign capture = !done_r && (settle_r == `STRAP_SETTLE);

  always_comb begin
    settle_nxt = settle_r;
    done_nxt   = done_r;
    strap_nxt  = strap_r;
    if (!done_r && !capture) begin
      settle_nxt = settle_r + 2'h1;
    end
    if (capture) begin
      done_nxt = 1'b1;
      strap_nxt.phy_station_address = {2'b00, s_rxd[1], s_rxd[2], s_rxd[3]};
      strap_nxt.interface_config =
        phy_strap_pkg::mode_t'({s_rxdv, s_crs, s_col});
      strap_nxt.duplex_full = ~s_rxd[0];
      strap_nxt.isolate     = s_rxer;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_r <= 2'h0;
      done_r   <= 1'b0;
      strap_r  <= '0;
    end else begin
      settle_r <= settle_nxt;
      done_r   <= done_nxt;
      strap_r  <= strap_nxt;
    end
  end

  assign strap        = strap_r;
  assign straps_valid = done_r;

  // register file over apb
  logic [4:0]         idx;
  logic               wr_acc, rd_setup, mapped;
  logic [15:0]        ctrl_r, ctrl_nxt;
  logic [15:0]        adv_r, adv_nxt;
  logic [15:0]        phyctl_r, phyctl_nxt;
  logic [INT_SRC-1:0] int_en_r, int_en_nxt;
  logic [INT_SRC-1:0] int_sts_r, int_sts_nxt;
  logic               int_pol_r, int_pol_nxt;
  logic [31:0]        rdata_r, rdata_nxt;
  logic [15:0]        rxerr_cnt;
  logic               rxerr_clr, err_lvl, err_q_r;
  logic               int_clr;

  assign idx      = paddr[6:2];
  assign mapped   = (paddr[7] == 1'b0) && (paddr[1:0] == 2'b00) &&
                    (idx == `REG_CTRL_IDX || idx == `REG_ID2_IDX ||
                     idx == `REG_ADV_IDX || idx == `REG_PHYCTL_IDX ||
                     idx == `REG_RXERR_IDX || idx == `REG_STRAP_IDX ||
                     idx == `REG_INT_IDX);
  assign wr_acc   = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite && mapped;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = rdata_r;

  // read side effects happen once, at the setup cycle
  assign rxerr_clr = rd_setup && (idx == `REG_RXERR_IDX);
  assign int_clr   = rd_setup && (idx == `REG_INT_IDX);

  // symbol errors are folded into the receive error level
  assign err_lvl = rx_core.rx_er | rx_core.sym_err;

  rx_err_counter #(.W(16)) u_rxerr (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (err_lvl && !err_q_r),
    .clr     (rxerr_clr),
    .count   (rxerr_cnt)
  );

  always_comb begin
    ctrl_nxt    = ctrl_r;
    adv_nxt     = adv_r;
    phyctl_nxt  = phyctl_r;
    int_en_nxt  = int_en_r;
    int_pol_nxt = int_pol_r;
    rdata_nxt   = rdata_r;
    // set wins over the read clear
    int_sts_nxt = (int_clr ? '0 : int_sts_r) | int_evt;
    if (capture) begin
      ctrl_nxt[`CTRL_DUPLEX_BIT] = ~s_rxd[0];
      ctrl_nxt[`CTRL_ISO_BIT]    = s_rxer;
      phyctl_nxt[`PHYCTL_PRE100_BIT] =
        ({s_rxdv, s_crs, s_col} == phy_strap_pkg::MODE_MII_PRE);
    end else if (wr_acc) begin
      unique case (idx)
        `REG_CTRL_IDX:   ctrl_nxt = pwdata[15:0];
        `REG_ADV_IDX:    adv_nxt = pwdata[15:0];
        `REG_PHYCTL_IDX: phyctl_nxt = pwdata[15:0];
        `REG_INT_IDX: begin
          int_en_nxt  = pwdata[`INT_EN_LSB +: INT_SRC];
          int_pol_nxt = pwdata[`INT_POL_BIT];
        end
        default: ;
      endcase
    end
    if (rd_setup) begin
      rdata_nxt = 32'h0000_0000;
      unique case (idx)
        `REG_CTRL_IDX:   rdata_nxt[15:0] = ctrl_r;
        `REG_ID2_IDX:    rdata_nxt[15:0] = {`ID2_MODEL_RST, SILICON_REV};
        `REG_ADV_IDX:    rdata_nxt[15:0] = adv_r;
        `REG_PHYCTL_IDX: rdata_nxt[15:0] = phyctl_r;
        `REG_RXERR_IDX:  rdata_nxt[15:0] = rxerr_cnt;
        `REG_STRAP_IDX:  rdata_nxt[10:0] = {done_r, strap_r};
        `REG_INT_IDX: begin
          rdata_nxt[INT_SRC-1:0]                = int_sts_r;
          rdata_nxt[`INT_EN_LSB +: INT_SRC]     = int_en_r;
          rdata_nxt[`INT_POL_BIT]               = int_pol_r;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= `CTRL_RST;
      adv_r     <= `ADV_RST;
      phyctl_r  <= `PHYCTL_RST;
      int_en_r  <= '0;
      int_sts_r <= '0;
      int_pol_r <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      err_q_r   <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      adv_r     <= adv_nxt;
      phyctl_r  <= phyctl_nxt;
      int_en_r  <= int_en_nxt;
      int_sts_r <= int_sts_nxt;
      int_pol_r <= int_pol_nxt;
      rdata_r   <= rdata_nxt;
      err_q_r   <= err_lvl;
    end
  end

  // pin mux; strap pin outputs held undriven until straps are taken, mdio enable follows mdio_drv
  phy_strap_pkg::mode_t mode;
  logic                 drive_ok, is_rmii, is_mii;
  logic [3:0]           rxd_nxt, rxd_oe_nxt;
  logic                 rxdv_nxt, rxer_nxt, col_nxt, crs_nxt, txc_nxt, txc_oe_nxt;
  logic                 dv_oe_nxt, er_oe_nxt, cc_oe_nxt, irq_nxt, mdc_q_r;
  phy_strap_pkg::tx_core_t tx_nxt;

  assign mode     = strap_r.interface_config;
  assign drive_ok = done_r && !ctrl_r[`CTRL_ISO_BIT];
  assign is_rmii  = (mode == phy_strap_pkg::MODE_RMII) ||
                    (mode == phy_strap_pkg::MODE_RMII_B2B);
  assign is_mii   = !is_rmii && (mode != phy_strap_pkg::MODE_SMII);

  always_comb begin
    rxd_nxt    = rx_core.rxd;
    rxdv_nxt   = rx_core.rx_dv;
    rxer_nxt   = err_lvl;
    col_nxt    = rx_core.col;
    crs_nxt    = rx_core.crs;
    txc_nxt    = rx_core.tx_clk;
    rxd_oe_nxt = {4{drive_ok}};
    dv_oe_nxt  = drive_ok;
    er_oe_nxt  = drive_ok;
    cc_oe_nxt  = drive_ok && is_mii;
    txc_oe_nxt = drive_ok && is_mii && (mode != phy_strap_pkg::MODE_MII_B2B);
    if (is_rmii) begin
      rxdv_nxt   = rx_core.crs | rx_core.rx_dv;
      rxd_nxt    = {2'b00, rx_core.rxd[1:0]};
      rxd_oe_nxt = {2'b00, {2{drive_ok}}};
    end else if (!is_mii) begin
      rxd_nxt    = {3'b000, rx_core.smii_rx};
      rxd_oe_nxt = {3'b000, drive_ok};
      dv_oe_nxt  = 1'b0;
      er_oe_nxt  = 1'b0;
    end
    // level choice from the polarity bit: high when set, else low
    irq_nxt = int_pol_r ? |(int_sts_r & int_en_r) : ~|(int_sts_r & int_en_r);
    tx_nxt.tx_en     = s_txen;
    tx_nxt.txd       = s_txd;
    tx_nxt.tx_clk_in = (mode == phy_strap_pkg::MODE_MII_B2B) && s_txc;
    tx_nxt.smii_sync = (mode == phy_strap_pkg::MODE_SMII) && s_txd[1];
    tx_nxt.mdio_bit  = tx_core.mdio_bit;
    tx_nxt.mdio_stb  = s_mdc && !mdc_q_r;
    if (s_mdc && !mdc_q_r) begin
      tx_nxt.mdio_bit = s_mdio;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_o                 <= 4'h0;
      rxd_oe                <= 4'h0;
      rxdv_o                <= 1'b0;
      rxdv_oe               <= 1'b0;
      rxer_o                <= 1'b0;
      rxer_oe               <= 1'b0;
      col_o                 <= 1'b0;
      col_oe                <= 1'b0;
      crs_o                 <= 1'b0;
      crs_oe                <= 1'b0;
      transmit_clock_pin_o  <= 1'b0;
      transmit_clock_pin_oe <= 1'b0;
      interrupt_output      <= 1'b1;
      tx_core               <= '0;
      mdc_q_r               <= 1'b0;
      mdio_o                <= 1'b0;
      mdio_oe               <= 1'b0;
    end else begin
      rxd_o                 <= rxd_nxt;
      rxd_oe                <= rxd_oe_nxt;
      rxdv_o                <= rxdv_nxt;
      rxdv_oe               <= dv_oe_nxt;
      rxer_o                <= rxer_nxt;
      rxer_oe               <= er_oe_nxt;
      col_o                 <= col_nxt;
      col_oe                <= cc_oe_nxt;
      crs_o                 <= crs_nxt;
      crs_oe                <= cc_oe_nxt;
      transmit_clock_pin_o  <= txc_nxt;
      transmit_clock_pin_oe <= txc_oe_nxt;
      interrupt_output      <= irq_nxt;
      tx_core               <= tx_nxt;
      mdc_q_r               <= s_mdc;
      mdio_o                <= mdio_bit_out;
      mdio_oe               <= mdio_drv;
    end
  end

  // reference clock choice follows the latched mode
  always_comb begin
    unique case (mode)
      phy_strap_pkg::MODE_RMII,
      phy_strap_pkg::MODE_RMII_B2B: ref_sel = phy_strap_pkg::REF_50M;
      phy_strap_pkg::MODE_SMII:     ref_sel = phy_strap_pkg::REF_125M;
      default:                      ref_sel = phy_strap_pkg::REF_25M;
    endcase
  end
  assign crystal_input_allowed = is_mii;
endmodule

// >>> verif/strap_mux_checker_sva.sv
// assertions on strap capture and pin mux
`timescale 1ns/1ps
module strap_mux_checker (
  input wire logic                    pclk, // clock
  input wire logic                    presetn, // reset
  input wire logic [3:0]              rxd_i, // pin
  input wire logic                    rxdv_i, // pin
  input wire logic                    rxer_i, // pin
  input wire logic                    col_i, // pin
  input wire logic                    crs_i, // pin
  input wire logic [3:0]              rxd_oe, // enable
  input wire logic                    rxdv_o, // data
  input wire logic                    rxdv_oe, // enable
  input wire logic                    rxer_o, // data
  input wire logic                    rxer_oe, // enable
  input wire logic                    transmit_clock_pin_oe, // enable
  input wire logic                    mdc_i, // mgmt clock
  input wire phy_strap_pkg::rx_core_t rx_core, // core
  input wire phy_strap_pkg::tx_core_t tx_core, // core
  input wire phy_strap_pkg::strap_t   strap, // straps
  input wire logic                    straps_valid // done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cap; $rose(straps_valid); endsequence
  property p_addr; s_cap |-> strap[9:5] == {2'h0, $past({rxd_i[1], rxd_i[2], rxd_i[3]})};
  endproperty
  property p_cfg; s_cap |-> strap[4:0] == $past({rxdv_i, crs_i, col_i, !rxd_i[0], rxer_i});
  endproperty
  property p_hold; straps_valid && $past(straps_valid) |-> $stable(strap); endproperty
  property p_iso; s_cap ##0 strap.isolate |=> (!rxdv_oe && !rxer_oe && rxd_oe == 4'h0) [*3];
  endproperty
  property p_crsdv; rxdv_oe && strap.interface_config == phy_strap_pkg::MODE_RMII |->
    rxdv_o == $past(rx_core.crs | rx_core.rx_dv); endproperty
  property p_txc; straps_valid && strap.interface_config == phy_strap_pkg::MODE_MII_B2B |->
    !transmit_clock_pin_oe; endproperty
  property p_rxer; rxer_oe |-> rxer_o == $past(rx_core.rx_er | rx_core.sym_err); endproperty
  property p_mdio; $rose(mdc_i) |-> ##[2:5] tx_core.mdio_stb; endproperty
  a_addr: assert property (p_addr) else $error("address strap wrong");
  a_cfg: assert property (p_cfg) else $error("mode strap wrong");
  a_hold: assert property (p_hold) else $error("straps moved");
  a_iso: assert property (p_iso) else $error("isolated pins driven");
  a_crsdv: assert property (p_crsdv) else $error("combined valid wrong");
  a_txc: assert property (p_txc) else $error("tx clock driven");
  a_rxer: assert property (p_rxer) else $error("error pin wrong");
  a_mdio: assert property (p_mdio) else $error("mgmt sample missing");
endmodule
bind phy_pin_strap_mux strap_mux_checker chk_u (.pclk, .presetn, .rxd_i, .rxdv_i, .rxer_i,
  .col_i, .crs_i, .rxd_oe, .rxdv_o, .rxdv_oe, .rxer_o, .rxer_oe, .transmit_clock_pin_oe,
  .mdc_i, .rx_core, .tx_core, .strap, .straps_valid);

// >>> verif/mac_far_model.sv
// mac and management station model
`timescale 1ns/1ps
module mac_far_model (
  input  wire logic       pclk,   // clock
  input  wire logic [7:0] pull,   // {rxer,rxdv,crs,col,rxd}
  input  wire logic       smii,   // sync wanted
  input  wire logic       mgmt,   // mgmt frame
  input  wire logic [3:0] rxd_o,  // phy
  input  wire logic [3:0] rxd_oe, // phy
  input  wire logic       rxdv_o, // phy
  input  wire logic       rxdv_oe, // phy
  input  wire logic       rxer_o, // phy
  input  wire logic       rxer_oe, // phy
  input  wire logic       col_o,  // phy
  input  wire logic       col_oe, // phy
  input  wire logic       crs_o,  // phy
  input  wire logic       crs_oe, // phy
  input  wire logic       mdio_o, // phy
  input  wire logic       mdio_oe, // phy
  output logic      [3:0] rxd_i,  // pin
  output logic            rxdv_i, // pin
  output logic            rxer_i, // pin
  output logic            col_i,  // pin
  output logic            crs_i,  // pin
  output logic            mdc_i,  // pin
  output logic            mdio_i, // pin
  output logic      [3:0] txd_i   // pin
);
  logic [3:0] div = 4'h0;
  logic       sta = 1'b0;
  // released pins fall to their pull level
  assign rxd_i = (rxd_oe & rxd_o) | (~rxd_oe & pull[3:0]);
  assign col_i = col_oe ? col_o : pull[4];
  assign crs_i = crs_oe ? crs_o : pull[5];
  assign rxdv_i = rxdv_oe ? rxdv_o : pull[6];
  assign rxer_i = rxer_oe ? rxer_o : pull[7];
  assign mdio_i = mdio_oe ? mdio_o : (mgmt ? sta : 1'b1);
  // 12.5 MHz from ten pclk cycles
  assign mdc_i = mgmt & (div >= 4'h5);
  assign txd_i = {div[0], div[1], smii ? div == 4'h0 : div[2], div[3]};
  always @(posedge pclk) begin
    div <= ((mgmt | smii) && div != 4'h9) ? div + 4'h1 : 4'h0;
    sta <= (div == 4'h0) ? ~sta : sta;
  end
endmodule

// >>> verif/phy_mac_side_pin_strap_mux_test.sv
// bench for the strap and pin mux block
`timescale 1ns/1ps
`include "phy_strap_regs.svh"
module phy_mac_side_pin_strap_mux_test;
  localparam logic [3:0] REV = 4'h7; // arbitrary revision value
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        txen_i = 1'b0, transmit_clock_pin_i = 1'b0, mdio_drv = 1'b0, mdio_bit_out = 1'b0;
  logic        smii = 1'b0, mgmt = 1'b0, e, pready, pslverr, rxdv_i, rxdv_o, rxdv_oe;
  logic        rxer_i, rxer_o, rxer_oe, col_i, col_o, col_oe, crs_i, crs_o, crs_oe, mdc_i;
  logic        transmit_clock_pin_o, transmit_clock_pin_oe, mdio_i, mdio_o, mdio_oe;
  logic        interrupt_output, crystal_input_allowed, straps_valid;
  logic [1:0]  err = 2'h0;
  logic [3:0]  int_evt = 4'h0, rxd_i, rxd_o, rxd_oe, txd_i;
  logic [7:0]  paddr = 8'h00, pull = 8'h01;
  logic [31:0] pwdata = 32'h0, q, prdata;
  integer      seed = 98, n_errors = 0, comparisons = 0, cyc = 0, n_stb = 0;
  phy_strap_pkg::rx_core_t rx_core = '0;
  phy_strap_pkg::tx_core_t tx_core;
  phy_strap_pkg::strap_t   strap;
  phy_strap_pkg::ref_sel_t ref_sel;

  phy_pin_strap_mux #(.SILICON_REV(REV)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rxd_i, .rxd_o, .rxd_oe, .rxdv_i, .rxdv_o, .rxdv_oe,
    .rxer_i, .rxer_o, .rxer_oe, .col_i, .col_o, .col_oe, .crs_i, .crs_o, .crs_oe,
    .transmit_clock_pin_i, .transmit_clock_pin_o, .transmit_clock_pin_oe, .txen_i, .txd_i,
    .mdc_i, .mdio_i, .mdio_o, .mdio_oe, .interrupt_output, .rx_core, .mdio_drv, .mdio_bit_out,
    .int_evt, .tx_core, .strap, .ref_sel, .crystal_input_allowed, .straps_valid);
  mac_far_model far (.pclk, .pull, .smii, .mgmt, .rxd_o, .rxd_oe, .rxdv_o, .rxdv_oe, .rxer_o,
    .rxer_oe, .col_o, .col_oe, .crs_o, .crs_oe, .mdio_o, .mdio_oe, .rxd_i, .rxdv_i, .rxer_i,
    .col_i, .crs_i, .mdc_i, .mdio_i, .txd_i);

  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    rx_core <= (11'($random(seed)) & 11'h7cf) | {5'h00, err, 4'h0};
    {txen_i, transmit_clock_pin_i, mdio_drv, mdio_bit_out} <= 4'($random(seed));
    n_stb <= n_stb + (tx_core.mdio_stb === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end

  function automatic logic [9:0] sx(input logic [7:0] p);
    return {2'h0, p[1], p[2], p[3], p[6:4], ~p[0], p[7]};
  endfunction
  function automatic logic [1:0] rs(input logic [2:0] m);
    return (m == 3'h1 || m == 3'h5) ? 2'h1 : (m == 3'h2 ? 2'h2 : 2'h0);
  endfunction
  function automatic logic [3:0] ox(input logic [7:0] p);
    return p[7] ? 4'h0 : (rs(p[6:4]) == 2'h1 ? 4'h3 : (rs(p[6:4]) == 2'h2 ? 4'h1 : 4'hf));
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] i, input logic [15:0] x);
    apb(1'b0, {1'b0, i, 2'h0}, 32'h0);
    chk(q, {16'h0, x});
  endtask
  task automatic wr(input logic [4:0] i, input logic [15:0] x);
    apb(1'b1, {1'b0, i, 2'h0}, {16'h0, x});
  endtask
  task automatic ev(input logic [3:0] v);
    @(posedge pclk);
    int_evt <= v;
    @(posedge pclk);
    int_evt <= 4'h0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic rst(input logic [7:0] p);
    @(posedge pclk);
    presetn <= 1'b0;
    pull <= p;
    smii <= (p[6:4] == 3'h2);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 9; i++) begin
      rst({i == 8, 3'(i), 4'($random(seed))});
      chk(strap, sx(pull));
      rd(`REG_STRAP_IDX, {6'h01, sx(pull)});
      rd(`REG_CTRL_IDX, {5'h00, pull[7], 1'b0, ~pull[0], 8'h00});
      rd(`REG_PHYCTL_IDX, {8'h00, pull[6:4] == 3'h4, 7'h00});
      rd(`REG_ADV_IDX, `ADV_RST);
      chk(ref_sel, rs(pull[6:4]));
      chk(crystal_input_allowed, rs(pull[6:4]) == 2'h0);
      chk(rxd_oe, ox(pull));
      if (pull[6:4] == 3'h0 || pull[6:4] == 3'h6) begin
        chk(transmit_clock_pin_oe, pull[6:4] == 3'h0 && !pull[7]);
      end
    end
    rst({4'h0, 4'($random(seed))});
    chk(interrupt_output, 1'b1);
    wr(`REG_INT_IDX, 16'h0010);
    ev(4'h1);
    chk(interrupt_output, 1'b0);
    rd(`REG_INT_IDX, 16'h0011);
    ev(4'h2);
    chk(interrupt_output, 1'b1);
    rd(`REG_INT_IDX, 16'h0012);
    wr(`REG_INT_IDX, 16'h0210);
    repeat (3) @(posedge pclk);
    chk(interrupt_output, 1'b0);
    ev(4'h1);
    chk(interrupt_output, 1'b1);
    wr(`REG_ADV_IDX, 16'h09e1);
    rd(`REG_ADV_IDX, 16'h09e1);
    wr(`REG_PHYCTL_IDX, 16'h00c0);
    rd(`REG_PHYCTL_IDX, 16'h00c0);
    wr(`REG_ID2_IDX, 16'h0000);
    rd(`REG_ID2_IDX, {`ID2_MODEL_RST, REV});
    apb(1'b0, 8'h08, 32'h0);
    chk(e, 1'b1);
    rd(`REG_RXERR_IDX, 16'h0000);
    for (int j = 1; j < 4; j++) begin
      @(posedge pclk);
      err <= 2'(j);
      @(posedge pclk);
      err <= 2'h0;
      repeat (2) @(posedge pclk);
    end
    rd(`REG_RXERR_IDX, 16'h0003);
    rd(`REG_RXERR_IDX, 16'h0000);
    @(posedge pclk);
    mgmt <= 1'b1;
    repeat (60) @(posedge pclk);
    mgmt <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(n_stb, 6);
    wrap_up();
  end
endmodule
